// ---- design/protect_pkg.sv ----
/*
  Shared constants and types for the sector protection block: opcodes,
  status byte layout, global action codes, link states and pin bundle.
  Assumes a single 25 MHz core clock and a serial link sampled by it.
*/
package protect_pkg;

  // Command opcodes, one byte each, most significant bit first.
  localparam logic [7:0] CMD_WRITE_STATUS     = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS      = 8'h05;
  localparam logic [7:0] CMD_READ_PROTECTION  = 8'h3C;
  localparam logic [7:0] CMD_PROTECT_SECTOR   = 8'h36;
  localparam logic [7:0] CMD_UNPROTECT_SECTOR = 8'h39;

  // Status byte layout.
  localparam int LOCK_POS    = 7;
  localparam int WP_POS      = 4;
  localparam int SUMMARY_LSB = 2;
  localparam int GLOBAL_LSB  = 2;

  // Software protection summary encodings.
  localparam logic [1:0] SUMMARY_NONE = 2'h0;
  localparam logic [1:0] SUMMARY_SOME = 2'h1;
  localparam logic [1:0] SUMMARY_ALL  = 2'h3;

  // Global action codes found in status write bits 5 to 2.
  localparam logic [3:0] GLOBAL_UNPROTECT = 4'h0;
  localparam logic [3:0] GLOBAL_PROTECT   = 4'hF;

  // Reset values.
  localparam logic LOCK_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  // Address framing.
  localparam int ADDR_BYTES = 3;
  localparam int SECTOR_LSB = 16;

  // Link protocol states.
  typedef enum logic [2:0] {
    S_CMD, S_ADDR, S_WDATA, S_STAT, S_SPR, S_SKIP
  } link_state_type;

  // What the address phase is for.
  typedef enum logic [1:0] {
    OP_READ, OP_PROTECT, OP_UNPROTECT
  } sector_op_type;

  // Serial pins that cross into the core clock domain.
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } pins_type;

  localparam pins_type PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};

endpackage

// ---- design/pin_sync.sv ----
/*
  Two flip-flop synchroniser for a bundle of asynchronous inputs.
  Assumes the inputs change slowly compared with the core clock.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int                 WIDTH     = 4,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Asynchronous inputs and their synchronised copy.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second one.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pin_sync

// ---- design/sector_flags.sv ----
/*
  Bank of per-sector protection flags with global set and clear,
  single flag update, registered read and registered summary.
  Assumes at most one update request per cycle; global ops win.
*/
`timescale 1ns/1ns
module sector_flags
  import protect_pkg::*;
#(
  parameter int COUNT = 64,
  parameter int IDX_W = 6
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Update requests.
  input  wire logic             set_all,
  input  wire logic             clr_all,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic             wr_val,
  // Read port and summary.
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic                  rd_flag,
  output logic                  all_set,
  output logic                  any_set
);

  if (COUNT != (1 << IDX_W)) begin : g_check
    $error("sector_flags: COUNT must equal two to the power IDX_W");
  end

  logic [COUNT-1:0] flags;
  logic [COUNT-1:0] next_flags;

  // Next flag values: global actions override a single update.
  always_comb begin
    next_flags = flags;
    if (set_all) begin
      next_flags = '1;
    end else if (clr_all) begin
      next_flags = '0;
    end else if (wr_en) begin
      next_flags[wr_idx] = wr_val;
    end
  end

  // Flags, read data and summary all come from flip-flops.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags   <= {COUNT{FLAG_RESET}};
      rd_flag <= FLAG_RESET;
      all_set <= FLAG_RESET;
      any_set <= FLAG_RESET;
    end else begin
      flags   <= next_flags;
      rd_flag <= flags[rd_idx];
      all_set <= &flags;
      any_set <= |flags;
    end
  end

endmodule // sector_flags

// ---- design/sector_protection_control.sv ----
/*
  Sector protection control behind a mode 0/3 serial slave link:
  status write decode with global protect and unprotect, lock bit with
  soft and hard locking, status read and sector protection read.
  Assumes the link pins are asynchronous and the serial clock runs well
  below a quarter of ref_clk, so each edge is seen by the core clock.
*/
`timescale 1ns/1ns
module sector_protection_control
  import protect_pkg::*;
#(
  parameter int SECTORS  = 64,
  parameter int SECT_W   = 6
) (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Serial link pins.
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  output logic            so,
  output logic            so_oe,
  // Write-protect pin, active low.
  input  wire logic       wp_n,
  // Status seen by the rest of the device.
  output logic            protection_lock_bit,
  output logic [1:0]      software_protection_summary
);

  if (SECTOR_LSB + SECT_W > 8 * ADDR_BYTES) begin : g_check
    $error("sector_protection_control: sector index exceeds the address");
  end

  pins_type            pins_raw;
  pins_type            pins;
  logic                sck_d;
  logic                sck_rise;
  logic                sck_fall;
  logic                cs_idle;
  link_state_type      state;
  link_state_type      next_state;
  sector_op_type       op;
  sector_op_type       next_op;
  logic [2:0]          bit_cnt;
  logic [2:0]          next_bit_cnt;
  logic [1:0]          byte_cnt;
  logic [1:0]          next_byte_cnt;
  logic [7:0]          shift;
  logic [7:0]          next_shift;
  logic [23:0]         addr;
  logic [23:0]         next_addr;
  logic [2:0]          out_cnt;
  logic [2:0]          next_out_cnt;
  logic [7:0]          out_shift;
  logic [7:0]          next_out_shift;
  logic                next_so;
  logic                next_so_oe;
  logic                lock;
  logic                next_lock;
  logic [7:0]          in_byte;
  logic [23:0]         full_addr;
  logic                byte_done;
  logic                hard_lock;
  logic                wr_fire;
  logic                set_all;
  logic                clr_all;
  logic                sect_wr;
  logic                bank_rd;
  logic                all_set;
  logic                any_set;
  logic [7:0]          status_byte;
  logic [7:0]          src_byte;

  // Bring the link pins and the write-protect pin into the core domain.
  assign pins_raw = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};

  pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (PINS_IDLE)
  ) u_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  // Serial clock edges and framing seen on the synchronised copies.
  assign sck_rise  = pins.sck & ~sck_d;
  assign sck_fall  = ~pins.sck & sck_d;
  assign cs_idle   = pins.cs_n;
  assign in_byte   = {shift[6:0], pins.si};
  assign byte_done = (bit_cnt == 3'h7);
  assign full_addr = {addr[15:0], in_byte};
  assign hard_lock = lock & ~pins.wp_n;

  // Summary and status byte; written bits 5 to 2 are never echoed back.
  always_comb begin
    if (all_set) begin
      software_protection_summary = SUMMARY_ALL;
    end else if (any_set) begin
      software_protection_summary = SUMMARY_SOME;
    end else begin
      software_protection_summary = SUMMARY_NONE;
    end
    status_byte                            = '0;
    status_byte[LOCK_POS]                  = lock;
    status_byte[WP_POS]                    = pins.wp_n;
    status_byte[SUMMARY_LSB +: 2]          = software_protection_summary;
    src_byte = (state == S_SPR) ? {8{bank_rd}} : status_byte;
  end

  // Status write decode: lock bit update and global actions.
  always_comb begin
    wr_fire   = ~cs_idle & sck_rise & (state == S_WDATA) & byte_done & ~hard_lock;
    next_lock = lock;
    set_all   = 1'b0;
    clr_all   = 1'b0;
    if (wr_fire) begin
      next_lock = in_byte[LOCK_POS];
      if (!lock) begin
        set_all = (in_byte[GLOBAL_LSB +: 4] == GLOBAL_PROTECT);
        clr_all = (in_byte[GLOBAL_LSB +: 4] == GLOBAL_UNPROTECT);
      end
    end
  end

  // Link protocol: command, address, data and output phases.
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_bit_cnt   = bit_cnt;
    next_byte_cnt  = byte_cnt;
    next_shift     = shift;
    next_addr      = addr;
    next_out_cnt   = out_cnt;
    next_out_shift = out_shift;
    next_so        = so;
    next_so_oe     = so_oe;
    sect_wr        = 1'b0;
    if (cs_idle) begin
      next_state    = S_CMD;
      next_bit_cnt  = '0;
      next_byte_cnt = '0;
      next_out_cnt  = '0;
      next_so_oe    = 1'b0;
    end else if (sck_rise) begin
      next_shift   = in_byte;
      next_bit_cnt = bit_cnt + 3'h1;
      case (state)
        S_CMD: begin
          if (byte_done) begin
            next_out_cnt = '0;
            case (in_byte)
              CMD_READ_STATUS:     next_state = S_STAT;
              CMD_READ_PROTECTION: begin
                next_state = S_ADDR;
                next_op    = OP_READ;
              end
              CMD_PROTECT_SECTOR: begin
                next_state = S_ADDR;
                next_op    = OP_PROTECT;
              end
              CMD_UNPROTECT_SECTOR: begin
                next_state = S_ADDR;
                next_op    = OP_UNPROTECT;
              end
              CMD_WRITE_STATUS: next_state = hard_lock ? S_SKIP : S_WDATA;
              default:          next_state = S_SKIP;
            endcase
          end
        end
        S_ADDR: begin
          if (byte_done) begin
            next_addr     = full_addr;
            next_byte_cnt = byte_cnt + 2'h1;
            if (byte_cnt == 2'(ADDR_BYTES - 1)) begin
              if (op == OP_READ) begin
                next_state = S_SPR;
              end else begin
                sect_wr    = ~lock;
                next_state = S_SKIP;
              end
            end
          end
        end
        S_WDATA: begin
          if (byte_done) begin
            next_state = S_SKIP;
          end
        end
        default: ;
      endcase
    end else if (sck_fall && (state == S_STAT || state == S_SPR)) begin
      // Output bits change on the falling edge; bytes repeat with fresh data.
      next_so_oe   = 1'b1;
      next_out_cnt = out_cnt + 3'h1;
      if (out_cnt == 3'h0) begin
        next_so        = src_byte[7];
        next_out_shift = {src_byte[6:0], 1'b0};
      end else begin
        next_so        = out_shift[7];
        next_out_shift = {out_shift[6:0], 1'b0};
      end
    end
  end

  // Register the link and lock state.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_d     <= 1'b0;
      state     <= S_CMD;
      op        <= OP_READ;
      bit_cnt   <= '0;
      byte_cnt  <= '0;
      shift     <= '0;
      addr      <= '0;
      out_cnt   <= '0;
      out_shift <= '0;
      so        <= 1'b0;
      so_oe     <= 1'b0;
      lock      <= LOCK_RESET;
    end else begin
      sck_d     <= pins.sck;
      state     <= next_state;
      op        <= next_op;
      bit_cnt   <= next_bit_cnt;
      byte_cnt  <= next_byte_cnt;
      shift     <= next_shift;
      addr      <= next_addr;
      out_cnt   <= next_out_cnt;
      out_shift <= next_out_shift;
      so        <= next_so;
      so_oe     <= next_so_oe;
      lock      <= next_lock;
    end
  end

  assign protection_lock_bit = lock;

  // One flag per sector, chosen by the upper address bits.
  sector_flags #(
    .COUNT (SECTORS),
    .IDX_W (SECT_W)
  ) u_flags (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .set_all (set_all),
    .clr_all (clr_all),
    .wr_en   (sect_wr),
    .wr_idx  (full_addr[SECTOR_LSB +: SECT_W]),
    .wr_val  (op == OP_PROTECT),
    .rd_idx  (addr[SECTOR_LSB +: SECT_W]),
    .rd_flag (bank_rd),
    .all_set (all_set),
    .any_set (any_set)
  );

  // Checks that tie outputs to their causes.
  a_global_unprotect: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_fire && !lock && in_byte == 8'h00 |=> !lock ##1 software_protection_summary == SUMMARY_NONE)
    else $error("global unprotect did not clear every flag");

  a_global_protect: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_fire && !lock && in_byte == 8'h7F |=> !lock ##1 software_protection_summary == SUMMARY_ALL)
    else $error("global protect did not set every flag");

  a_lock_with_protect: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_fire && !lock && in_byte == 8'hFF |=> lock ##1 software_protection_summary == SUMMARY_ALL)
    else $error("write of FFh did not protect and lock");

  a_soft_lock_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lock && pins.wp_n && wr_fire |-> !set_all && !clr_all)
    else $error("global action taken while soft locked");

  a_soft_unlock: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lock && pins.wp_n && wr_fire && !in_byte[7] |=> !lock)
    else $error("soft lock not released by bit 7 at zero");

  a_lock_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_fire && !lock && in_byte == 8'hF0 |-> !set_all && !clr_all && !sect_wr ##1 lock)
    else $error("write of F0h changed flags or failed to lock");

  a_decode_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_fire && in_byte[5:2] != 4'h0 && in_byte[5:2] != 4'hF |-> !set_all && !clr_all)
    else $error("partial global code caused an action");

  a_hard_lock: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lock && !pins.wp_n && !cs_idle |=> lock && !$past(sect_wr) && !$past(set_all))
    else $error("hard lock let the lock bit or flags change");

  a_spr_repeat: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == S_SPR && sck_fall && !cs_idle |=> so == $past(bank_rd) && so_oe)
    else $error("sector flag byte not driven on serial out");

  a_release_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cs_idle |=> !so_oe)
    else $error("serial out still driven after chip select rose");

endmodule // sector_protection_control

// ---- verification/spi_host_model.sv ----
/*
  Behavioural host for the serial link: frames one command per call,
  shifts bits out MSB first and captures bits from so.
  Assumes all pins change on falling edges of ref_clk; half sets the pace.
*/
`timescale 1ns/1ns
module spi_host_model (
  // Core clock that paces the link.
  input  wire logic ref_clk,
  // Link pins toward the block.
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  int   half = 4;  // Half period of sck in ref_clk cycles; 4 gives 160 ns.
  logic oe_seen;

  // Idle link: deselected, mode 0 clock low.
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Waits a number of falling edges of the core clock.
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Sends n_out bits of tx from bit 31 down, then captures n_in bits of so.
  // Each read bit is taken at the end of the high phase, long after so moved.
  task automatic xfer(input logic [31:0] tx, input int n_out, input int n_in,
                      output logic [15:0] rx);
    rx      = '0;
    oe_seen = 1'b1;
    tick(1);
    cs_n = 1'b0;
    tick(half);
    for (int i = 0; i < n_out + n_in; i++) begin
      si = (i < n_out) ? tx[31 - i] : ~si;
      tick(half);
      sck = 1'b1;
      tick(half);
      if (i >= n_out) begin
        // A released line has no pull, so it is seen as the inverse of its last value.
        rx      = {rx[14:0], so_oe ? so : ~so};
        oe_seen = oe_seen & so_oe;
      end
      sck = 1'b0;
    end
    tick(half);
    cs_n = 1'b1;
    si   = ~si;   // Released line shows no stale value.
    tick(8);
  endtask
endmodule // spi_host_model

// ---- verification/sector_protection_control_tb.sv ----
/*
  Self-checking bench for the sector protection block.
  Assumes the host model paces the link and the design's own assertions run.
*/
`timescale 1ns/1ns
module sector_protection_control_tb
  import protect_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        wp_n    = 1'b1;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        protection_lock_bit;
  logic [1:0]  software_protection_summary;
  logic [15:0] rx;
  int          n_errors = 0;
  int          n_tests  = 0;

  // 25 MHz core clock.
  always #20 ref_clk = ~ref_clk;

  spi_host_model host (
    .ref_clk (ref_clk), .cs_n (cs_n), .sck (sck), .si (si), .so (so), .so_oe (so_oe)
  );

  sector_protection_control #(.SECTORS(64), .SECT_W(6)) dut (
    .ref_clk (ref_clk), .arst_n (arst_n), .cs_n (cs_n), .sck (sck), .si (si),
    .so (so), .so_oe (so_oe), .wp_n (wp_n),
    .protection_lock_bit (protection_lock_bit),
    .software_protection_summary (software_protection_summary)
  );

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // Lock bit and summary together.
  task automatic chk_st(input logic lock, input logic [1:0] summ);
    chk({13'h0000, protection_lock_bit, software_protection_summary}, {13'h0000, lock, summ});
  endtask

  // Status byte expected from lock, pin and summary.
  function automatic logic [15:0] stat(input logic lock, input logic [1:0] summ);
    return {8'h00, lock, 2'b00, wp_n, summ, 2'b00};
  endfunction

  task automatic wr(input logic [7:0] v);
    host.xfer({CMD_WRITE_STATUS, v, 16'h0000}, 16, 0, rx);
  endtask

  task automatic rd_stat();
    host.xfer({CMD_READ_STATUS, 24'h00_0000}, 8, 8, rx);
  endtask

  task automatic rd_sec(input logic [23:0] a, input int n);
    host.xfer({CMD_READ_PROTECTION, a}, 32, n, rx);
  endtask

  task automatic sec_op(input logic [7:0] op, input logic [23:0] a);
    host.xfer({op, a}, 32, 0, rx);
  endtask

  // Values straight after reset.
  task automatic t_reset();
    chk_st(1'b0, 2'b00);
    chk({15'h0000, so_oe}, 16'h0000);
  endtask

  // Global protect and unprotect while unlocked, read back per sector.
  task automatic t_global();
    wr(8'h7F);
    chk_st(1'b0, 2'b11);
    rd_sec(24'h05_0000, 16);
    chk(rx, 16'hFFFF);
    chk({15'h0000, host.oe_seen}, 16'h0001);
    rd_stat();
    chk(rx, stat(1'b0, 2'b11));
    wr(8'h00);
    chk_st(1'b0, 2'b00);
    rd_sec(24'h3F_FFFF, 16);
    chk(rx, 16'h0000);
  endtask

  // Single sector protect, address within sector, early abort.
  task automatic t_sector();
    sec_op(CMD_PROTECT_SECTOR, 24'h05_1234);
    chk_st(1'b0, 2'b01);
    rd_sec(24'h05_FFFF, 16);
    chk(rx, 16'hFFFF);
    rd_sec(24'h06_0000, 16);
    chk(rx, 16'h0000);
    rd_sec(24'h05_0000, 11);
    chk(rx, 16'h07FF);
    chk({15'h0000, so_oe}, 16'h0000);
    sec_op(CMD_PROTECT_SECTOR, 24'h3F_0000);
    rd_sec(24'h3F_FFFF, 16);
    chk(rx, 16'hFFFF);
    sec_op(CMD_UNPROTECT_SECTOR, 24'h3F_8000);
    rd_sec(24'h3F_0000, 16);
    chk(rx, 16'h0000);
    chk_st(1'b0, 2'b01);
    wr(8'h24);
    chk_st(1'b0, 2'b01);
    rd_stat();
    chk(rx, stat(1'b0, 2'b01));
  endtask

  // Soft lock: sector and global changes refused, unlock then retry.
  task automatic t_soft();
    wr(8'hF0);
    chk_st(1'b1, 2'b01);
    sec_op(CMD_UNPROTECT_SECTOR, 24'h05_0000);
    chk_st(1'b1, 2'b01);
    wr(8'h7F);
    chk_st(1'b0, 2'b01);
    wr(8'h7F);
    chk_st(1'b0, 2'b11);
    wr(8'hFF);
    chk_st(1'b1, 2'b11);
    wr(8'h0F);
    chk_st(1'b0, 2'b11);
  endtask

  // Hard lock with the pin low: everything refused, read still works.
  task automatic t_hard();
    wr(8'hF0);
    wp_n = 1'b0;
    wr(8'h00);
    chk_st(1'b1, 2'b11);
    sec_op(CMD_UNPROTECT_SECTOR, 24'h02_0000);
    chk_st(1'b1, 2'b11);
    rd_stat();
    chk(rx, stat(1'b1, 2'b11));
    rd_sec(24'h02_0000, 16);
    chk(rx, 16'hFFFF);
    wp_n = 1'b1;
    wr(8'h0F);
    chk_st(1'b0, 2'b11);
  endtask

  // Raising the lock applies the encoded global action too.
  task automatic t_raise();
    wr(8'h83);
    chk_st(1'b1, 2'b00);
    rd_stat();
    chk(rx, stat(1'b1, 2'b00));
  endtask

  // Prints counts and verdict, then stops.
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence after six reset cycles.
  initial begin
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_global();
    t_sector();
    t_soft();
    t_hard();
    t_raise();
    wrap_up();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
endmodule // sector_protection_control_tb
